// File: pkg/dif_pkg.sv
// dif_pkg: register map, field positions, enums and counts for the
// digital input function block; shared by the block and its table memory.
package dif_pkg;
  // register byte offsets, decoded on haddr[7:0]
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SAFETY = 8'h04;
  localparam logic [7:0] OFF_SERIAL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_LIN = 8'h40;
  // control register field positions
  localparam int CTRL_LIN_BIT = 0;
  localparam int CTRL_POL_BIT = 1;
  localparam int CTRL_FSEL_LSB = 4;
  localparam int CTRL_SSEL_LSB = 8;
  localparam int CTRL_KIND_LSB = 12;
  localparam int CTRL_ROLE_LSB = 16;
  // serial function register bits
  localparam int SER_HOLD_BIT = 0;
  localparam int SER_SAFE_BIT = 1;
  localparam int SER_TRACK_BIT = 2;
  localparam int SER_CR_BIT = 3;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] SAFETY_RST = 16'h0000;
  localparam logic [3:0] SERIAL_RST = 4'h0;
  // function selector: six functions, repeated with acknowledgement
  localparam logic [3:0] FN_HOLD = 4'h0;
  localparam logic [3:0] FN_SAFETY = 4'h1;
  localparam logic [3:0] FN_TRACK = 4'h2;
  localparam logic [3:0] FN_READY = 4'h3;
  localparam logic [3:0] FN_SERIAL = 4'h4;
  localparam logic [3:0] FN_LOCK = 4'h5;
  localparam logic [3:0] FSEL_ACK_BASE = 4'h6;
  // serial-control selector value that hands functions to the bus
  localparam logic [1:0] SSEL_SERIAL = 2'h2;
  // plant roles for computer readiness
  localparam logic [1:0] ROLE_BACKUP = 2'h1;
  localparam logic [1:0] ROLE_SUPER = 2'h2;
  // 16-bit full scale: 50 % threshold
  localparam logic [15:0] HALF_SCALE = 16'h8000;
  // linearization table: nine breakpoints, eight segments
  localparam int LIN_POINTS = 9;
  localparam int LIN_AW = 4;
  localparam int X_W = 16;
  localparam int FRAC_W = 13;
  localparam logic [15:0] LIN_STEP = 16'h2000;
  // processing cycle in clocks (10 us at 100 MHz)
  localparam int CYCLE_CLOCKS_DEF = 1000;
  typedef enum logic [1:0] {
    KIND_CONT = 2'b00,
    KIND_TWOPOS = 2'b01,
    KIND_STEP_EXT = 2'b10,
    KIND_STEP_INT = 2'b11
  } dif_kind_t;
  // gray along local -> remote -> computer -> forced local
  typedef enum logic [1:0] {
    MODE_LOCAL = 2'b00,
    MODE_REMOTE = 2'b01,
    MODE_COMPUTER = 2'b11,
    MODE_ACKLOCAL = 2'b10
  } dif_mode_t;
endpackage

// File: pkg/dif_seg_if.sv
// dif_seg_if: write and dual read port of the linearization table.
// assumes the user drives addresses and write strobe, memory the data.
interface dif_seg_if;
  import dif_pkg::*;
  logic wrEn;
  logic [LIN_AW-1:0] wrAddr;
  logic [X_W-1:0] wrData;
  logic [LIN_AW-1:0] rdAddrA;
  logic [LIN_AW-1:0] rdAddrB;
  logic [X_W-1:0] rdDataA;
  logic [X_W-1:0] rdDataB;
  modport user (output wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
    input rdDataA, rdDataB);
  modport mem (input wrEn, wrAddr, wrData, rdAddrA, rdAddrB,
    output rdDataA, rdDataB);
endinterface

// File: logic/dif_seg_mem.sv
// dif_seg_mem: breakpoint table with two registered read ports.
// assumes one clock; reset loads a straight-line characteristic.
module dif_seg_mem
  import dif_pkg::*;
#(
  parameter int DEPTH = LIN_POINTS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // table port
  dif_seg_if.mem seg
);
  logic [X_W-1:0] tab_ff [DEPTH];

  if (DEPTH > 2 ** LIN_AW || DEPTH < 2) begin : g_bad_depth
    $error("dif_seg_mem: DEPTH does not fit the address width");
  end

  // reset gives identity, last point clipped to full scale
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        tab_ff[i] <= (i == DEPTH - 1) ? 16'hFFFF : X_W'(i * LIN_STEP);
      end
    end else if (seg.wrEn && 32'(seg.wrAddr) < DEPTH) begin
      tab_ff[seg.wrAddr] <= seg.wrData;
    end
  end

  // registered reads; out-of-range address reads the last point
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      seg.rdDataA <= '0;
      seg.rdDataB <= '0;
    end else begin
      seg.rdDataA <= tab_ff[32'(seg.rdAddrA) < DEPTH ? seg.rdAddrA : LIN_AW'(DEPTH - 1)];
      seg.rdDataB <= tab_ff[32'(seg.rdAddrB) < DEPTH ? seg.rdAddrB : LIN_AW'(DEPTH - 1)];
    end
  end
endmodule

// File: logic/dif_input_select.sv
// dif_input_select: field digital input with polarity and function
// select, output stage overrides, computer-readiness mode logic and
// x1 linearization, configured over an AHB-Lite slave.
// assumes one 100 MHz clock, synchronous active-low reset, one master.
//
// Local design decisions: the address map and the AHB-Lite register port.
module dif_input_select
  import dif_pkg::*;
#(
  parameter int CYCLE_CLOCKS = CYCLE_CLOCKS_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // field pins
  input wire logic fieldDigitalInput,
  input wire logic remoteKey,
  // algorithm side
  input wire logic [15:0] mainControlledVariable,
  input wire logic [15:0] algorithmOutput,
  input wire logic algStepUp,
  input wire logic algStepDown,
  input wire logic [15:0] trackingInput,
  // output stage
  output logic [15:0] manipulatedOut,
  output logic stepUpOut,
  output logic stepDownOut,
  output logic [15:0] linearizedOut,
  // modes and function states
  output logic computerMode,
  output logic localMode,
  output logic computerReady,
  output logic backupMode,
  output logic supervisoryMode,
  output logic serialOnlyInput,
  output logic frontPanelLockout
);
  localparam int CW = $clog2(CYCLE_CLOCKS + 1);

  if (CYCLE_CLOCKS < 2) begin : g_bad_cycle
    $error("dif_input_select: CYCLE_CLOCKS must be at least 2");
  end

  dif_seg_if seg ();

  // configuration and bus state
  logic linSel_ff, polSel_ff;
  logic [3:0] fnSel_ff;
  logic [1:0] serSel_ff, role_ff;
  dif_kind_t kind_ff;
  logic [15:0] safety_ff;
  logic [3:0] serFn_ff;
  logic wrPend_ff;
  logic [7:0] wrOff_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff, hresp_ff;
  // pins, cycle tick, sampled input
  logic [1:0] pinS1_ff, pinS2_ff, pinS3_ff, pinF_ff;
  logic [CW-1:0] cnt_ff;
  logic tick_ff, fieldLvl_ff, crPrev_ff;
  // mode machine and outputs
  dif_mode_t mode_ff, nxt_mode;
  logic compMode_ff, locMode_ff, cr_ff, backup_ff, super_ff;
  logic serOnly_ff, lock_ff;
  logic [15:0] yOut_ff;
  logic stepUp_ff, stepDown_ff;
  // linearization pipeline
  logic lin1_ff;
  logic [FRAC_W-1:0] frac1_ff;
  logic [15:0] x1_ff, linOut_ff, interp;
  logic signed [17:0] diffS, sumS;
  logic signed [31:0] prodS;
  // decoded functions
  logic [3:0] fnIdx;
  logic ackMode, serOn, keyRemote, isStep, crRise;
  logic effHold, effSafety, effTrack, effCr;

  // selectors 6..11 fold onto 0..5; 12..15 select nothing
  function automatic logic [3:0] fnIndex(input logic [3:0] sel);
    return (sel >= FSEL_ACK_BASE) ? 4'(sel - FSEL_ACK_BASE) : sel;
  endfunction

  function automatic logic isLin(input logic [7:0] off);
    return off >= OFF_LIN && off < 8'(OFF_LIN + 4 * LIN_POINTS) && off[1:0] == 2'b00;
  endfunction

  // ahb address phase: capture writes, prefetch read data
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wrPend_ff <= 1'b0;
      wrOff_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wrPend_ff <= hsel && htrans[1] && hready && hwrite;
      wrOff_ff <= haddr[7:0];
      hrdata_ff <= 32'h0000_0000;
      if (hsel && htrans[1] && hready && !hwrite) begin
        case (haddr[7:0])
          OFF_CTRL: begin
            hrdata_ff[CTRL_LIN_BIT] <= linSel_ff;
            hrdata_ff[CTRL_POL_BIT] <= polSel_ff;
            hrdata_ff[CTRL_FSEL_LSB +: 4] <= fnSel_ff;
            hrdata_ff[CTRL_SSEL_LSB +: 2] <= serSel_ff;
            hrdata_ff[CTRL_KIND_LSB +: 2] <= kind_ff;
            hrdata_ff[CTRL_ROLE_LSB +: 2] <= role_ff;
          end
          OFF_SAFETY: hrdata_ff[15:0] <= safety_ff;
          OFF_SERIAL: hrdata_ff[3:0] <= serFn_ff;
          OFF_STATUS: hrdata_ff[9:0] <= {serOnly_ff, lock_ff, cr_ff, locMode_ff,
            compMode_ff, effTrack, effSafety, effHold, fieldLvl_ff, 1'b0};
          default: hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // zero wait states, always okay
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // ahb data phase: register writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      linSel_ff <= CTRL_RST[CTRL_LIN_BIT];
      polSel_ff <= CTRL_RST[CTRL_POL_BIT];
      fnSel_ff <= CTRL_RST[CTRL_FSEL_LSB +: 4];
      serSel_ff <= CTRL_RST[CTRL_SSEL_LSB +: 2];
      kind_ff <= dif_kind_t'(CTRL_RST[CTRL_KIND_LSB +: 2]);
      role_ff <= CTRL_RST[CTRL_ROLE_LSB +: 2];
      safety_ff <= SAFETY_RST;
      serFn_ff <= SERIAL_RST;
    end else if (wrPend_ff) begin
      case (wrOff_ff)
        OFF_CTRL: begin
          linSel_ff <= hwdata[CTRL_LIN_BIT];
          polSel_ff <= hwdata[CTRL_POL_BIT];
          fnSel_ff <= hwdata[CTRL_FSEL_LSB +: 4];
          serSel_ff <= hwdata[CTRL_SSEL_LSB +: 2];
          kind_ff <= dif_kind_t'(hwdata[CTRL_KIND_LSB +: 2]);
          role_ff <= hwdata[CTRL_ROLE_LSB +: 2];
        end
        OFF_SAFETY: safety_ff <= hwdata[15:0];
        OFF_SERIAL: serFn_ff <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // table writes go straight to the segment memory
  assign seg.wrEn = wrPend_ff && isLin(wrOff_ff);
  assign seg.wrAddr = LIN_AW'((wrOff_ff - OFF_LIN) >> 2);
  assign seg.wrData = hwdata[15:0];

  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pinS1_ff <= 2'b00;
      pinS2_ff <= 2'b00;
      pinS3_ff <= 2'b00;
      pinF_ff <= 2'b00;
    end else begin
      pinS1_ff <= {remoteKey, fieldDigitalInput};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinF_ff <= (pinS2_ff & pinS3_ff) | (pinF_ff & (pinS2_ff ^ pinS3_ff));
    end
  end

  // processing cycle enable
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= cnt_ff == CW'(CYCLE_CLOCKS - 1);
      cnt_ff <= (cnt_ff == CW'(CYCLE_CLOCKS - 1)) ? '0 : cnt_ff + 1'b1;
    end
  end

  // sample once per cycle; ready starts high so reset makes no rise
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fieldLvl_ff <= 1'b0;
      crPrev_ff <= 1'b1;
    end else if (tick_ff) begin
      fieldLvl_ff <= pinF_ff[0] ^ polSel_ff;
      crPrev_ff <= effCr;
    end
  end

  // function decode; only the selected one follows the input
  always_comb begin
    fnIdx = fnIndex(fnSel_ff);
    ackMode = fnSel_ff >= FSEL_ACK_BASE;
    serOn = serSel_ff == SSEL_SERIAL;
    keyRemote = pinF_ff[1];
    isStep = kind_ff == KIND_STEP_EXT || kind_ff == KIND_STEP_INT;
    effHold = (fnIdx == FN_HOLD && fieldLvl_ff) || (serOn && serFn_ff[SER_HOLD_BIT]);
    effSafety = (fnIdx == FN_SAFETY && fieldLvl_ff) || (serOn && serFn_ff[SER_SAFE_BIT]);
    effTrack = (fnIdx == FN_TRACK && fieldLvl_ff) || (serOn && serFn_ff[SER_TRACK_BIT]);
    if (fnIdx == FN_READY) begin
      effCr = fieldLvl_ff || (serOn && serFn_ff[SER_CR_BIT]);
    end else begin
      effCr = serOn ? serFn_ff[SER_CR_BIT] : 1'b1;
    end
    crRise = tick_ff && effCr && !crPrev_ff;
  end

  // mode machine; a forced local is left only through key local
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      MODE_LOCAL: begin
        if (keyRemote) begin
          nxt_mode = effCr ? MODE_COMPUTER : MODE_REMOTE;
        end
      end
      MODE_REMOTE: begin
        if (!keyRemote) begin
          nxt_mode = MODE_LOCAL;
        end else if (crRise) begin
          nxt_mode = ackMode ? MODE_ACKLOCAL : MODE_COMPUTER;
        end
      end
      MODE_COMPUTER: begin
        if (!keyRemote) begin
          nxt_mode = MODE_LOCAL;
        end else if (!effCr) begin
          nxt_mode = MODE_REMOTE;
        end
      end
      MODE_ACKLOCAL: begin
        if (!keyRemote) begin
          nxt_mode = MODE_LOCAL;
        end
      end
      default: nxt_mode = MODE_LOCAL;
    endcase
  end

  // mode state and its mirrored outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_ff <= MODE_LOCAL;
      compMode_ff <= 1'b0;
      locMode_ff <= 1'b1;
    end else begin
      mode_ff <= nxt_mode;
      compMode_ff <= nxt_mode == MODE_COMPUTER;
      locMode_ff <= nxt_mode == MODE_LOCAL || nxt_mode == MODE_ACKLOCAL;
    end
  end

  // function outputs toward mode logic, panel and serial side
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cr_ff <= 1'b1;
      backup_ff <= 1'b0;
      super_ff <= 1'b0;
      serOnly_ff <= 1'b0;
      lock_ff <= 1'b0;
    end else begin
      cr_ff <= effCr;
      backup_ff <= role_ff == ROLE_BACKUP && effCr && nxt_mode == MODE_COMPUTER;
      super_ff <= role_ff == ROLE_SUPER && effCr && nxt_mode == MODE_COMPUTER;
      serOnly_ff <= fnIdx == FN_SERIAL && fieldLvl_ff;
      lock_ff <= fnIdx == FN_LOCK && fieldLvl_ff;
    end
  end

  // output stage; safety outranks hold, hold outranks tracking
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      yOut_ff <= 16'h0000;
      stepUp_ff <= 1'b0;
      stepDown_ff <= 1'b0;
    end else if (effSafety) begin
      if (kind_ff == KIND_STEP_INT) begin
        stepUp_ff <= safety_ff >= HALF_SCALE;
        stepDown_ff <= safety_ff < HALF_SCALE;
      end else begin
        yOut_ff <= safety_ff;
        stepUp_ff <= 1'b0;
        stepDown_ff <= 1'b0;
      end
    end else if (effHold) begin
      stepUp_ff <= 1'b0;
      stepDown_ff <= 1'b0;
    end else begin
      yOut_ff <= (effTrack && !isStep) ? trackingInput : algorithmOutput;
      stepUp_ff <= algStepUp;
      stepDown_ff <= algStepDown;
    end
  end

  // linearization stage one: segment lookup issued to the table
  assign seg.rdAddrA = LIN_AW'(mainControlledVariable[X_W-1:FRAC_W]);
  assign seg.rdAddrB = LIN_AW'(mainControlledVariable[X_W-1:FRAC_W]) + 1'b1;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lin1_ff <= 1'b0;
      frac1_ff <= '0;
      x1_ff <= 16'h0000;
    end else begin
      lin1_ff <= linSel_ff;
      frac1_ff <= mainControlledVariable[FRAC_W-1:0];
      x1_ff <= mainControlledVariable;
    end
  end

  // stage two: straight line between the two breakpoints
  always_comb begin
    diffS = $signed({2'b00, seg.rdDataB}) - $signed({2'b00, seg.rdDataA});
    // widen before the product; an 18-bit product would wrap on steep segments
    prodS = 32'(diffS) * 32'($signed({1'b0, frac1_ff}));
    sumS = $signed({2'b00, seg.rdDataA}) + 18'(prodS >>> FRAC_W);
    interp = sumS[15:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      linOut_ff <= 16'h0000;
    end else begin
      linOut_ff <= lin1_ff ? interp : x1_ff;
    end
  end

  dif_seg_mem #(
    .DEPTH(LIN_POINTS)
  ) u_seg_mem (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .seg(seg.mem)
  );

  // ports straight from flip-flops
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign manipulatedOut = yOut_ff;
  assign stepUpOut = stepUp_ff;
  assign stepDownOut = stepDown_ff;
  assign linearizedOut = linOut_ff;
  assign computerMode = compMode_ff;
  assign localMode = locMode_ff;
  assign computerReady = cr_ff;
  assign backupMode = backup_ff;
  assign supervisoryMode = super_ff;
  assign serialOnlyInput = serOnly_ff;
  assign frontPanelLockout = lock_ff;

  // checks on the guarded behaviour
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  lin_bypass_a: assert property (
    !lin1_ff |=> linOut_ff == $past(x1_ff)) else $error("bypass lost x1");
  lin_node_a: assert property (
    lin1_ff && frac1_ff == '0 |=> linOut_ff == $past(seg.rdDataA))
    else $error("breakpoint value wrong");
  field_sense_a: assert property (
    tick_ff |=> fieldLvl_ff == ($past(pinF_ff[0]) ^ $past(polSel_ff)))
    else $error("input sense wrong");
  hold_freeze_a: assert property (
    effHold && !effSafety |=> $stable(yOut_ff) && !stepUp_ff && !stepDown_ff)
    else $error("hold did not freeze");
  safety_value_a: assert property (
    effSafety && kind_ff != KIND_STEP_INT |=> yOut_ff == $past(safety_ff))
    else $error("safety value not driven");
  safety_step_a: assert property (
    effSafety && kind_ff == KIND_STEP_INT
    |=> stepUp_ff == ($past(safety_ff) >= HALF_SCALE) && stepDown_ff == !stepUp_ff)
    else $error("safety step direction wrong");
  track_path_a: assert property (
    effTrack && !effSafety && !effHold && !isStep |=> yOut_ff == $past(trackingInput))
    else $error("tracking path wrong");
  lockout_a: assert property (
    fnIdx == FN_LOCK && fieldLvl_ff |=> frontPanelLockout) else $error("no lockout");
  ready_idle_a: assert property (
    !serOn |-> (fnIdx == FN_READY || effCr) && (fnIdx == FN_HOLD || !effHold)
    && (fnIdx == FN_SAFETY || !effSafety) && (fnIdx == FN_TRACK || !effTrack))
    else $error("unselected default wrong");
  direct_comp_a: assert property (
    mode_ff == MODE_REMOTE && keyRemote && crRise && !ackMode
    |=> computerMode && mode_ff == MODE_COMPUTER) else $error("no computer mode");
  ack_local_a: assert property (
    mode_ff == MODE_REMOTE && keyRemote && crRise && ackMode
    |=> localMode && !computerMode) else $error("no forced local");
  ack_hold_a: assert property (
    mode_ff == MODE_ACKLOCAL && keyRemote |=> mode_ff == MODE_ACKLOCAL)
    else $error("coupling restored early");
endmodule

// File: tb/dif_field_contact.sv
// dif_field_contact: field contact wired to the digital input pin.
// assumes the bench opens and closes it just after a clock edge.
module dif_field_contact (
  // contact state
  input wire logic wired,
  input wire logic closed,
  // pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // an unwired input floats to the pull-down level, read as zero
  assign pin = wired & closed;
endmodule

// File: tb/dif_input_select_tb_top.sv
// dif_input_select_tb_top: self-checking bench with an inline model.
// assumes CYCLE_CLOCKS of 4, so pin changes settle within 16 clocks.
module dif_input_select_tb_top import dif_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, pinClosed = 0;
  logic remoteKey = 0, fieldPin, hreadyout, hresp, stepUpOut, stepDownOut;
  logic computerMode, localMode, computerReady, backupMode, supervisoryMode;
  logic serialOnlyInput, frontPanelLockout;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, sx;
  logic [31:0] rnd = 32'h0000_f55b;
  logic [15:0] xIn = 0, algOut = 0, trackIn = 0, sv, a0, manipulatedOut, linearizedOut;
  int errTotal = 0, nCompared = 0, fn;
  dif_field_contact dif_field_contact_i (.wired(1'b1), .closed(pinClosed), .pin(fieldPin));
  dif_input_select #(.CYCLE_CLOCKS(4)) dif_input_select_i (.ref_clk(ref_clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fieldDigitalInput(fieldPin),
    .remoteKey(remoteKey), .mainControlledVariable(xIn), .algorithmOutput(algOut),
    .algStepUp(algOut[3]), .algStepDown(algOut[5]), .trackingInput(trackIn),
    .manipulatedOut(manipulatedOut), .stepUpOut(stepUpOut), .stepDownOut(stepDownOut),
    .linearizedOut(linearizedOut), .computerMode(computerMode), .localMode(localMode),
    .computerReady(computerReady), .backupMode(backupMode),
    .supervisoryMode(supervisoryMode), .serialOnlyInput(serialOnlyInput),
    .frontPanelLockout(frontPanelLockout));
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // control word: role, kind, serial select, function select, polarity, lin
  function automatic logic [31:0] ctl(logic l, logic p, logic [3:0] f, logic [1:0] s,
    logic [1:0] k, logic [1:0] r);
    return {14'h0, r, 2'h0, k, 2'h0, s, f, 2'h0, p, l};
  endfunction
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // single ahb transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nCompared++;
    if (g !== e) begin
      errTotal++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    if (errTotal == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard, well beyond the roughly 1500 clocks the sequence needs
  initial begin
    settle(20000);
    errTotal++;
    give_verdict();
  end
  // main sequence
  initial begin
    settle(2);
    resetn <= 1'b1;
    settle(1);
    chk({computerMode, localMode, computerReady, manipulatedOut}, 32'h0003_0000);
    ahb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    // each selector 0..11 under both polarities; model picks the output source
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 12; f++) begin
        rnd = nx(rnd);
        sv = rnd[15:0];
        a0 = rnd[31:16];
        rnd = nx(rnd);
        ahb(1'b1, OFF_CTRL, ctl(1'b0, p[0], f[3:0], 2'h0, KIND_CONT, 2'h0));
        ahb(1'b1, OFF_SAFETY, {16'h0, sv});
        pinClosed <= p[0];
        algOut <= a0;
        trackIn <= rnd[31:16];
        settle(16);
        pinClosed <= !p[0];
        settle(16);
        algOut <= rnd[15:0];
        settle(3);
        fn = f % 6;
        sx = fn == 1 ? sv : fn == 0 ? a0 : fn == 2 ? rnd[31:16] : rnd[15:0];
        chk(manipulatedOut, sx);
        ahb(1'b0, OFF_STATUS, 32'h0);
        sx = 32'h80 | (fn < 3 ? 32'h4 << fn : 32'h0);
        sx = sx | (fn == 4 ? 32'h200 : 32'h0) | (fn == 5 ? 32'h100 : 32'h0);
        chk(rd & 32'h0000_039C, sx);
        chk({29'h0, hresp, serialOnlyInput, frontPanelLockout},
          {29'h0, 1'b0, fn == 4, fn == 5});
      end
    end
    // readiness rise in remote, without and with acknowledgement
    for (int s = 3; s < 12; s += 6) begin
      ahb(1'b1, OFF_CTRL, ctl(1'b0, 1'b0, s[3:0], 2'h0, KIND_CONT,
        s == 3 ? ROLE_BACKUP : ROLE_SUPER));
      pinClosed <= 1'b0;
      remoteKey <= 1'b0;
      settle(16);
      remoteKey <= 1'b1;
      settle(16);
      chk({computerMode, localMode}, 32'h0);
      pinClosed <= 1'b1;
      settle(16);
      chk({computerMode, localMode, backupMode, supervisoryMode},
        s == 3 ? 32'hA : 32'h4);
      remoteKey <= 1'b0;
      settle(16);
      remoteKey <= 1'b1;
      settle(16);
      chk({computerMode, localMode, backupMode, supervisoryMode},
        s == 3 ? 32'hA : 32'h9);
    end
    // bus-written functions with serial control handed to the bus
    pinClosed <= 1'b0;
    ahb(1'b1, OFF_CTRL, ctl(1'b0, 1'b0, FN_SERIAL, SSEL_SERIAL, KIND_CONT, 2'h0));
    for (int i = 0; i < 16; i++) begin
      ahb(1'b1, OFF_SERIAL, i);
      settle(8);
      ahb(1'b0, OFF_STATUS, 32'h0);
      chk((rd & 32'h0000_009C) | {23'h0, computerReady, 8'h0},
        {23'h0, i[3], i[3], 2'h0, i[2:0], 2'h0});
    end
    ahb(1'b0, OFF_SERIAL, 32'h0);
    chk(rd, 32'h0000_000F);
    // safety on step kinds at both sides of the half-scale threshold
    pinClosed <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      sv = k == 1 ? HALF_SCALE : 16'h7FFF;
      ahb(1'b1, OFF_CTRL, ctl(0, 0, FN_SAFETY, 2'h0, k < 2 ? KIND_STEP_INT : KIND_STEP_EXT, 0));
      ahb(1'b1, OFF_SAFETY, {16'h0, sv});
      settle(16);
      if (k < 2) begin
        chk({stepUpOut, stepDownOut}, k == 1 ? 32'h2 : 32'h1);
      end else begin
        chk({stepUpOut, stepDownOut, manipulatedOut}, {14'h0, 2'h0, sv});
      end
    end
    // half-slope table: breakpoints i*0x1000 make the output x/2
    for (int i = 0; i < LIN_POINTS; i++) begin
      ahb(1'b1, OFF_LIN + 8'(4 * i), i * 32'h1000);
    end
    for (int l = 0; l < 2; l++) begin
      ahb(1'b1, OFF_CTRL, ctl(l[0], 1'b0, FN_HOLD, 2'h0, KIND_CONT, 2'h0));
      // first value sits on a breakpoint, the rest are random
      for (int j = 0; j < 6; j++) begin
        rnd = nx(rnd);
        sv = j == 0 ? 16'h6000 : rnd[15:0];
        xIn <= sv;
        settle(4);
        chk(linearizedOut, l == 1 ? {1'b0, sv[15:1]} : sv);
      end
    end
    give_verdict();
  end
endmodule
